// ---- core/fcdp_channel.sv ----
// Purpose: one modulator channel, duty plus narrow-pulse insertion
// Assumes: slot and frame counters are shared and advance on tick
// Notes: narrow pulse is one modulator clock, placed just after the duty high time
`timescale 1ns/10ps
module fcdp_channel (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] setting,
  input  wire logic [4:0] slot,
  input  wire logic [2:0] frame_idx,
  output logic            wave_ff
);
  wire logic [4:0] duty      = setting[7:3];
  wire logic [2:0] np_count  = setting[2:0];
  // spread pulses by bit-reversed frame index so n pulses land in n of 8 cycles
  wire logic [2:0] rev_idx   = {frame_idx[0], frame_idx[1], frame_idx[2]};
  wire logic       add_pulse = rev_idx < np_count;
  wire logic       in_duty   = slot < duty;
  // at full duty the pulse fills the last slot, so the count still holds there
  wire logic       at_pulse  = add_pulse && (slot == duty);
  wire logic       nxt_wave  = in_duty || at_pulse;

  always_ff @(posedge clk) begin
    if (!reset_n) wave_ff <= 1'b0;
    else          wave_ff <= nxt_wave;
  end
endmodule : fcdp_channel

// ---- core/fcdp_pkg.sv ----
// Purpose: constants for the five-channel duty pulse generator
// Assumes: 8-bit registers on 32-bit ahb-lite words, clk is the oscillator
// Notes:
// Contract
// - there are five independent channels, each with its own 8-bit setting register.
// - a setting holds a 5-bit duty field in bits 7:3 and a 3-bit narrow-pulse count in bits 2:0.
// - in each frame of 8 modulator cycles the channel adds exactly as many narrow pulses as its count.
// - duty plus narrow pulses give 8-bit resolution at the 5-bit repetition rate.
// - the modulator clock is the oscillator divided by 2 to the power of (select + 1).
// - one output cycle lasts 32 modulator clocks.
// - the divider select sits in bits 1:0 of the clock control register, bits 7:2 unused.
// - pin enable bits 7:3 route channels 4:0 to their pins, a cleared bit leaves the pin as i/o.
// - reset clears all five channel output enable bits.
// - channel settings sit at offsets a4, a5, a6, a7 for channels 0-3 and ac for channel 4.
package fcdp_pkg;
  localparam int          NUM_CHANNELS   = 5;
  localparam int          DUTY_WIDTH     = 5;
  localparam int          NP_WIDTH       = 3;
  localparam int          DUTY_LSB       = 3;
  localparam int          ENABLE_LSB     = 3;
  localparam int          SELECT_WIDTH   = 2;
  localparam int          FRAME_CYCLES   = 8;
  localparam int          CYCLE_CLOCKS   = 32;
  localparam logic [7:0]  ADDR_PIN_EN    = 8'h9B;
  localparam logic [7:0]  ADDR_CLK_CTRL  = 8'hA3;
  localparam logic [7:0]  ADDR_CH0       = 8'hA4;
  localparam logic [7:0]  ADDR_CH1       = 8'hA5;
  localparam logic [7:0]  ADDR_CH2       = 8'hA6;
  localparam logic [7:0]  ADDR_CH3       = 8'hA7;
  localparam logic [7:0]  ADDR_CH4       = 8'hAC;
  localparam logic [7:0]  RESET_SETTING  = 8'h00;
  localparam logic [7:0]  RESET_PIN_EN   = 8'h00;
  localparam logic [1:0]  RESET_SELECT   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
endpackage : fcdp_pkg

// ---- core/fcdp_top.sv ----
// Purpose: five-channel duty pulse generator with ahb-lite register slave
// Assumes: single word transfers, zero wait states, always okay
// Notes: pins not enabled drive the general i/o value instead of the wave
`timescale 1ns/10ps
module fcdp_top #(
  parameter int NUM_CH = fcdp_pkg::NUM_CHANNELS
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [NUM_CH-1:0] gpio_out,
  output logic      [NUM_CH-1:0] pin_out_ff,
  output logic      [NUM_CH-1:0] pin_is_modulator_ff
);
  // registers and internal signals
  logic              wr_pend_ff;
  logic [7:0]        wr_addr_ff;
  logic [7:0]        setting_ff [NUM_CH];
  logic [7:0]        pin_en_ff;
  logic [1:0]        clock_divider_select_ff;
  logic [3:0]        presc_ff;
  logic [4:0]        slot_ff;
  logic [2:0]        frame_ff;
  logic [31:0]       rdata_ff;
  logic [7:0]        rd_mux;
  wire logic [NUM_CH-1:0] wave;

  // address phase qualifiers
  wire logic       is_nonseq = htrans == fcdp_pkg::HTRANS_NONSEQ;
  wire logic       take      = hsel && hready && is_nonseq;
  wire logic       take_wr   = take && hwrite;
  wire logic       take_rd   = take && !hwrite;
  // index is the byte address over four, so the odd offsets stay distinct words
  wire logic [7:0] word_adr  = haddr[9:2];

  function automatic logic [7:0] ch_addr(input int idx);
    case (idx)
      0:       ch_addr = fcdp_pkg::ADDR_CH0;
      1:       ch_addr = fcdp_pkg::ADDR_CH1;
      2:       ch_addr = fcdp_pkg::ADDR_CH2;
      3:       ch_addr = fcdp_pkg::ADDR_CH3;
      default: ch_addr = fcdp_pkg::ADDR_CH4;
    endcase
  endfunction : ch_addr

  // tick spacing minus one for each divider select
  function automatic logic [3:0] presc_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_limit = 4'h1;
      2'h1:    presc_limit = 4'h3;
      2'h2:    presc_limit = 4'h7;
      default: presc_limit = 4'hF;
    endcase
  endfunction : presc_limit

  // one-hot channel decode of a register index, shared by write and read
  function automatic logic [NUM_CH-1:0] ch_hits(input logic [7:0] idx);
    ch_hits = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      ch_hits[i] = idx == ch_addr(i);
    end
  endfunction : ch_hits

  // address phase decode for the read mux
  wire logic              rd_hit_pin_en   = word_adr == fcdp_pkg::ADDR_PIN_EN;
  wire logic              rd_hit_clk_ctrl = word_adr == fcdp_pkg::ADDR_CLK_CTRL;
  wire logic [NUM_CH-1:0] rd_hit_ch       = ch_hits(word_adr);

  // a write is taken in the address phase and lands with hwdata one cycle later
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= take_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_addr_ff <= 8'h00;
    end else begin
      wr_addr_ff <= word_adr;
    end
  end

  // data phase write strobes, one per register
  wire logic              wr_pin_en   = wr_pend_ff && (wr_addr_ff == fcdp_pkg::ADDR_PIN_EN);
  wire logic              wr_clk_ctrl = wr_pend_ff && (wr_addr_ff == fcdp_pkg::ADDR_CLK_CTRL);
  wire logic [NUM_CH-1:0] wr_ch       = wr_pend_ff ? ch_hits(wr_addr_ff) : '0;

  // unused bits of the two control registers are never stored
  wire logic [7:0] nxt_pin_en               = {hwdata[7:3], 3'h0};
  wire logic [1:0] nxt_clock_divider_select = hwdata[1:0];

  // registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_en_ff <= fcdp_pkg::RESET_PIN_EN;
    end else if (wr_pin_en) begin
      pin_en_ff <= nxt_pin_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clock_divider_select_ff <= fcdp_pkg::RESET_SELECT;
    end else if (wr_clk_ctrl) begin
      clock_divider_select_ff <= nxt_clock_divider_select;
    end
  end

  // setting writes act at once, so a change mid-cycle shows one clock later, within the current slot
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          setting_ff[g] <= fcdp_pkg::RESET_SETTING;
        end else if (wr_ch[g]) begin
          setting_ff[g] <= hwdata[7:0];
        end
      end

      fcdp_channel u_ch (
        .clk       (clk),
        .reset_n   (reset_n),
        .setting   (setting_ff[g]),
        .slot      (slot_ff),
        .frame_idx (frame_ff),
        .wave_ff   (wave[g])
      );
    end
  endgenerate

  // read mux, answered in the data phase one cycle after the address phase
  wire logic [7:0] rd_pin_en   = rd_hit_pin_en ? pin_en_ff : 8'h00;
  wire logic [7:0] rd_clk_ctrl = rd_hit_clk_ctrl ? {6'h00, clock_divider_select_ff} : 8'h00;

  always_comb begin
    rd_mux = rd_pin_en | rd_clk_ctrl;
    for (int i = 0; i < NUM_CH; i++) begin
      if (rd_hit_ch[i]) begin
        rd_mux = rd_mux | setting_ff[i];
      end
    end
  end

  // unmapped reads answer zero; hrdata holds until the next read
  wire logic [31:0] nxt_rdata = {24'h000000, rd_mux};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (take_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata    = rdata_ff;
  // zero wait states and no error response: every transfer completes at once
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // prescaler: one modulator tick every 2^(sel+1) clocks
  wire logic [3:0] presc_top = presc_limit(clock_divider_select_ff);
  // after a divider change a count above the new limit ends the tick at once
  wire logic       tick      = presc_ff >= presc_top;
  wire logic [3:0] nxt_presc = tick ? 4'h0 : presc_ff + 4'h1;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      presc_ff <= 4'h0;
    end else begin
      presc_ff <= nxt_presc;
    end
  end

  // slot counts modulator clocks within one output cycle
  wire logic       slot_last = slot_ff == 5'(fcdp_pkg::CYCLE_CLOCKS - 1);
  wire logic [4:0] nxt_slot  = tick ? slot_ff + 5'h01 : slot_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slot_ff <= 5'h00;
    end else begin
      slot_ff <= nxt_slot;
    end
  end

  // frame counts output cycles, eight to a frame of narrow-pulse slots
  wire logic       frame_step = tick && slot_last;
  wire logic [2:0] nxt_frame  = frame_step ? frame_ff + 3'h1 : frame_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_ff <= 3'h0;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  // pin routing, registered so each pin comes straight from a flop
  wire logic [NUM_CH-1:0] nxt_pin_is_modulator;
  wire logic [NUM_CH-1:0] nxt_pin_out;

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pin
      assign nxt_pin_is_modulator[g] = pin_en_ff[fcdp_pkg::ENABLE_LSB+g];
      assign nxt_pin_out[g]          = nxt_pin_is_modulator[g] ? wave[g] : gpio_out[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_is_modulator_ff <= '0;
    end else begin
      pin_is_modulator_ff <= nxt_pin_is_modulator;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_out_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
    end
  end
endmodule : fcdp_top

// ---- testbench/fcdp_load.sv ----
// Purpose: load on one modulator pin
// Assumes: window opened and closed by the bench
// Notes: a filter only sees the mean, so high clocks are counted
`timescale 1ns/10ps
module fcdp_load (
  input  wire logic   clk,
  input  wire logic   pin,
  input  wire logic   win,
  output logic [15:0] cnt_ff,
  output logic        done_ff
);
  logic win_d_ff;
  always_ff @(posedge clk) begin
    win_d_ff <= win;
    done_ff <= win_d_ff && !win;
    if (win && !win_d_ff) cnt_ff <= 16'(pin);
    else if (win) cnt_ff <= cnt_ff + 16'(pin);
  end
endmodule : fcdp_load

// ---- testbench/fcdp_monitor.sv ----
// Purpose: port checker for fcdp_top
// Assumes: one clock, synchronous reset
// Notes: register contents are judged by the bench
`timescale 1ns/10ps
module fcdp_monitor #(parameter int NUM_CH = 5) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic [NUM_CH-1:0] gpio_out,
  input wire logic [NUM_CH-1:0] pin_out_ff,
  input wire logic [NUM_CH-1:0] pin_is_modulator_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire       rq = hsel && hready && htrans == 2'h2;
  wire       rd = rq && !hwrite;
  wire [7:0] ix = haddr[9:2];
  logic      wph_ff;
  always_ff @(posedge clk) wph_ff <= rq && hwrite && ix == 8'h9B;
  AST_RST_EN: assert property ($rose(reset_n) |-> pin_is_modulator_ff == '0)
    else $error("enables not clear after reset");
  AST_RST_PIN: assert property ($rose(reset_n) |-> pin_out_ff == '0)
    else $error("pins not quiet after reset");
  AST_IO_CH0: assert property (!pin_is_modulator_ff[0] ##1 !pin_is_modulator_ff[0]
    |-> pin_out_ff[0] == $past(gpio_out[0])) else $error("pin 0 not general i/o");
  AST_IO_CH4: assert property (!pin_is_modulator_ff[NUM_CH-1] ##1 !pin_is_modulator_ff[NUM_CH-1]
    |-> pin_out_ff[NUM_CH-1] == $past(gpio_out[NUM_CH-1])) else $error("pin 4 not i/o");
  AST_RD_PIN: assert property (rd && ix == 8'h9B |=> hrdata[2:0] == 3'h0 && hrdata[31:8] == 24'h0)
    else $error("pin enable unused bits set");
  AST_RD_CTRL: assert property (rd && ix == 8'hA3 |=> hrdata[31:2] == 30'h0)
    else $error("control unused bits set");
  AST_RD_CH: assert property (rd && (ix[7:2] == 6'h29 || ix == 8'hAC) |=> hrdata[31:8] == 24'h0)
    else $error("setting wider than a byte");
  AST_EN_CHG: assert property ($changed(pin_is_modulator_ff) && $past(reset_n)
    |-> $past(wph_ff) || $past(wph_ff, 2)) else $error("enables moved without a write");
endmodule : fcdp_monitor
bind fcdp_top fcdp_monitor #(.NUM_CH(NUM_CH)) mon (.*);

// ---- testbench/fcdp_top_tb.sv ----
// Purpose: self-checking bench for fcdp_top
// Assumes: 100 MHz clock, zero-wait slave
// Notes: duty is judged by mean high time over 8 output cycles
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module fcdp_top_tb;
  logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, win = 0, rph = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, e;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  gpio_out = 0, pin_out_ff, pin_is_modulator_ff;
  logic        hready, hreadyout, hresp, done_ff;
  logic [15:0] cnt_ff;
  logic [7:0]  rnd = 8'h31, sv[5], adr[5] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAC};
  logic [31:0] q[$];
  int          fail_count = 0, compares = 0, ch = 0;
  assign hready = hreadyout;
  always #5 clk = ~clk;
  fcdp_top dut (.*);
  fcdp_load load (.clk, .pin(pin_out_ff[ch]), .win, .cnt_ff, .done_ff);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    gpio_out <= rnd[4:0];
  end
  task summarize();
    $display("mismatches %0d, compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task wt();
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin fail_count++; summarize(); end
  endtask : wt
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; haddr <= {22'h0, a, 2'h0}; htrans <= 2'h2; hwrite <= w;
    wt();
    htrans <= 0; hwdata <= w ? d : 0; rph <= !w;
    if (!w) q.push_back(d);
    wt();
    rph <= 0;
  endtask : xf
  // settling after a divider change costs at most one slow tick
  task mes(input int c, input logic [1:0] s, input logic [7:0] v);
    int n;
    n = 1 << (s + 1);
    xf(1, 8'hA3, {30'h0, s});
    xf(1, adr[c], {24'h0, v});
    ch <= c;
    repeat (40) @(posedge clk);
    win <= 1;
    repeat (n * 256) @(posedge clk);
    win <= 0;
    q.push_back(n * (8 * v[7:3] + v[2:0]));
  endtask : mes
  always @(negedge clk) if (rph || done_ff) begin
    e = q.size() ? q.pop_front() : 32'hDEAD;
    `CHK(rph ? hrdata : {16'h0, cnt_ff}, e)
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1;
    xf(0, 8'h9B, 0);
    xf(0, 8'h55, 0);
    xf(1, 8'hA3, 32'hFF); xf(0, 8'hA3, 3);
    xf(1, 8'h9B, 32'h08); xf(0, 8'h9B, 32'h08);
    xf(1, 8'h9B, 32'hFF); xf(0, 8'h9B, 32'hF8);
    for (int i = 0; i < 5; i++) begin sv[i] = rnd ^ 8'(i); xf(1, adr[i], {24'hFFFFFF, sv[i]}); end
    for (int i = 0; i < 5; i++) xf(0, adr[i], {24'h0, sv[i]});
    mes(0, 0, 8'h83);
    mes(1, 1, 8'hF8);
    mes(2, 2, 8'h07);
    mes(3, 3, 8'hFF);
    for (int i = 0; i < 5; i++) mes(i, 2'(i), rnd);
    repeat (5) @(posedge clk);
    summarize();
  end
endmodule : fcdp_top_tb
